// >>> vpu_defines.svh
// Register map, field positions and reset values of the pixel unpacker
`ifndef VPU_DEFINES_SVH
`define VPU_DEFINES_SVH
// Register byte offsets
`define VPU_CTRL_OFS      8'h00
`define VPU_MASK_OFS      8'h04
`define VPU_STAT_OFS      8'h08
// Control register fields
`define VPU_C_FMT         1:0
`define VPU_C_W64         2
`define VPU_C_NIB         3
`define VPU_C_BSW         4
`define VPU_C_B8DIR       5
`define VPU_C_HIPATH      7:6
`define VPU_C_POL         8
`define VPU_C_LIN         9
`define VPU_C_CONTIG      10
`define VPU_C_565         11
`define VPU_CTRL_BITS     12
`define VPU_CTRL_RST      12'h000
// Mask register fields
`define VPU_M_MASK        7:0
`define VPU_M_BANK        11:8
`define VPU_MASK_BITS     12
`define VPU_MASK_RST      12'h0FF
// Status register fields
`define VPU_S_WORDS       15:0
`define VPU_S_CNT         19:16
`define VPU_S_BUSY        20
// Hicolor path codes
`define VPU_PATH_IND      2'h0
`define VPU_PATH_DYN      2'h1
`define VPU_PATH_DIR      2'h3
// Pixel field slices
`define VPU_P565_R        15:11
`define VPU_P565_G        10:5
`define VPU_P555_R        14:10
`define VPU_P555_G        9:5
`define VPU_P_B           4:0
`define VPU_P_CTL         15
// Last pixel index per word, by format and width
`define VPU_LAST4_64      4'hF
`define VPU_LAST4_32      4'h7
`define VPU_LAST8_64      4'h7
`define VPU_LAST8_32      4'h3
`define VPU_LAST16_64     4'h3
`define VPU_LAST16_32     4'h1
`endif

// >>> vpu_pkg.sv
// Types shared by the pixel unpacker
package vpu_pkg;
    typedef enum logic [1:0] {
        VPU_FMT_4  = 2'h0,
        VPU_FMT_8  = 2'h1,
        VPU_FMT_16 = 2'h2,
        VPU_FMT_RS = 2'h3
    } vpu_fmt_t;
    typedef enum logic [1:0] {
        VPU_ST_IDLE = 2'b01,
        VPU_ST_EMIT = 2'b10
    } vpu_state_t;
endpackage

// >>> vpu_unpacker.sv
// Video memory word unpacker: 4/8/15/16 bpp to palette index or direct colour
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
`include "vpu_defines.svh"

module vpu_unpacker (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Video memory side, one word per load strobe
    input  wire logic        word_load_clock_i,
    input  wire logic [63:0] pixel_port_bus_i,
    output logic             word_ready_o,
    // Palette / DAC side
    output logic             pix_valid_o,
    output logic             pix_bypass_o,
    output logic      [7:0]  pix_red_o,
    output logic      [7:0]  pix_grn_o,
    output logic      [7:0]  pix_blu_o
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB register file
    logic [`VPU_CTRL_BITS-1:0] ctrl_r;
    logic [`VPU_CTRL_BITS-1:0] ctrl_nxt;
    logic [`VPU_MASK_BITS-1:0] mask_r;
    logic [`VPU_MASK_BITS-1:0] mask_nxt;
    logic [31:0]               prdata_r;
    logic [31:0]               prdata_nxt;
    logic [31:0]               stat_w;
    logic [15:0]               words_r;
    logic [3:0]                cnt_r;
    logic                      busy_w;
    logic                      hit_w;
    logic                      wr_acc_w;

    // Only three words decode; anything else errors on the access phase
    assign hit_w = (paddr_i == `VPU_CTRL_OFS) || (paddr_i == `VPU_MASK_OFS)
                || (paddr_i == `VPU_STAT_OFS);
    assign wr_acc_w  = psel_i && penable_i && pwrite_i && hit_w;
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit_w;
    assign prdata_o  = prdata_r;

    // Status shows the unpacker's own progress
    always_comb begin
        stat_w              = 32'h0000_0000;
        stat_w[`VPU_S_WORDS] = words_r;
        stat_w[`VPU_S_CNT]   = cnt_r;
        stat_w[`VPU_S_BUSY]  = busy_w;
    end

    // Next register values; read data is captured in the setup cycle
    always_comb begin
        ctrl_nxt   = ctrl_r;
        mask_nxt   = mask_r;
        prdata_nxt = prdata_r;
        if (wr_acc_w && paddr_i == `VPU_CTRL_OFS) begin
            ctrl_nxt = pwdata_i[`VPU_CTRL_BITS-1:0];
        end
        if (wr_acc_w && paddr_i == `VPU_MASK_OFS) begin
            mask_nxt = pwdata_i[`VPU_MASK_BITS-1:0];
        end
        if (psel_i && !penable_i && !pwrite_i) begin
            unique case (paddr_i)
                `VPU_CTRL_OFS: prdata_nxt = {20'h0_0000, ctrl_r};
                `VPU_MASK_OFS: prdata_nxt = {20'h0_0000, mask_r};
                `VPU_STAT_OFS: prdata_nxt = stat_w;
                default:       prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r   <= `VPU_CTRL_RST;
            mask_r   <= `VPU_MASK_RST;
            prdata_r <= 32'h0000_0000;
        end else begin
            ctrl_r   <= ctrl_nxt;
            mask_r   <= mask_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration fields
    vpu_pkg::vpu_fmt_t fmt_w;
    logic              w64_w;
    logic              nib_swap_w;
    logic              byte_swap_w;
    logic              b8_dir_w;
    logic [1:0]        hipath_w;
    logic              pol_w;
    logic              lin_w;
    logic              contig_w;
    logic              f565_w;
    logic [7:0]        pmask_w;
    logic [3:0]        bank_w;

    assign fmt_w       = vpu_pkg::vpu_fmt_t'(ctrl_r[`VPU_C_FMT]);
    assign w64_w       = ctrl_r[`VPU_C_W64];
    assign nib_swap_w  = ctrl_r[`VPU_C_NIB];
    assign byte_swap_w = ctrl_r[`VPU_C_BSW];
    assign b8_dir_w    = ctrl_r[`VPU_C_B8DIR];
    assign hipath_w    = ctrl_r[`VPU_C_HIPATH];
    assign pol_w       = ctrl_r[`VPU_C_POL];
    assign lin_w       = ctrl_r[`VPU_C_LIN];
    assign contig_w    = ctrl_r[`VPU_C_CONTIG];
    assign f565_w      = ctrl_r[`VPU_C_565];
    assign pmask_w     = mask_r[`VPU_M_MASK];
    assign bank_w      = mask_r[`VPU_M_BANK];

    ////////////////////////////////////////////////////////////////////////
    // Word holding and pixel sequencing
    vpu_pkg::vpu_state_t state_r;
    vpu_pkg::vpu_state_t state_nxt;
    logic [63:0]         word_r;
    logic [63:0]         word_nxt;
    logic [63:0]         swapped_w;
    logic [3:0]          cnt_nxt;
    logic [3:0]          last_w;
    logic [15:0]         words_nxt;
    logic                take_w;
    logic                at_last_w;

    // Pixels per word from format and memory width
    always_comb begin
        unique case (fmt_w)
            vpu_pkg::VPU_FMT_4:  last_w = w64_w ? `VPU_LAST4_64
                                                : `VPU_LAST4_32;
            vpu_pkg::VPU_FMT_16: last_w = w64_w ? `VPU_LAST16_64
                                                : `VPU_LAST16_32;
            default:             last_w = w64_w ? `VPU_LAST8_64
                                                : `VPU_LAST8_32;
        endcase
    end

    assign busy_w       = (state_r == vpu_pkg::VPU_ST_EMIT);
    assign at_last_w    = busy_w && (cnt_r == last_w);
    // A new word is accepted while idle or as the last pixel leaves
    assign word_ready_o = !busy_w || at_last_w;
    assign take_w       = word_load_clock_i && word_ready_o;

    // Byte pairs exchanged once at load so every format sees it
    always_comb begin
        swapped_w = pixel_port_bus_i;
        if (byte_swap_w) begin
            for (int i = 0; i < 4; i++) begin
                swapped_w[16*i +: 8]   = pixel_port_bus_i[16*i+8 +: 8];
                swapped_w[16*i+8 +: 8] = pixel_port_bus_i[16*i +: 8];
            end
        end
    end

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        word_nxt  = word_r;
        cnt_nxt   = cnt_r;
        words_nxt = words_r;
        if (busy_w) begin
            cnt_nxt = cnt_r + 4'h1;
        end
        if (at_last_w && !take_w) begin
            state_nxt = vpu_pkg::VPU_ST_IDLE;
        end
        if (take_w) begin
            state_nxt = vpu_pkg::VPU_ST_EMIT;
            word_nxt  = swapped_w;
            cnt_nxt   = 4'h0;
            words_nxt = words_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= vpu_pkg::VPU_ST_IDLE;
            word_r  <= 64'h0000_0000_0000_0000;
            cnt_r   <= 4'h0;
            words_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            word_r  <= word_nxt;
            cnt_r   <= cnt_nxt;
            words_r <= words_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel selection: bit offset grows byte by byte from bit 0 upward; within a byte, 4 bpp nibble order follows the swap
    logic [5:0]  off_w;
    logic [63:0] shifted_w;
    logic [15:0] raw_w;

    always_comb begin
        unique case (fmt_w)
            // High nibble first unless swapped; swap only matters here
            vpu_pkg::VPU_FMT_4:  off_w = {cnt_r, 2'b00}
                                     ^ {3'b000, !nib_swap_w, 2'b00};
            vpu_pkg::VPU_FMT_16: off_w = {cnt_r[1:0], 4'h0};
            default:             off_w = {cnt_r[2:0], 3'b000};
        endcase
    end

    assign shifted_w = word_r >> off_w;
    assign raw_w     = shifted_w[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Pixel to palette index or direct colour
    logic       dyn_w;
    logic       is565_w;
    logic       sparse_w;
    logic       fill_w;
    logic       direct_w;
    logic [4:0] r5_w;
    logic [5:0] g6_w;
    logic [4:0] b5_w;
    logic [7:0] red_nxt;
    logic [7:0] grn_nxt;
    logic [7:0] blu_nxt;
    logic       byp_nxt;
    logic       valid_nxt;
    logic [7:0] pix_red_r;
    logic [7:0] pix_grn_r;
    logic [7:0] pix_blu_r;
    logic       pix_byp_r;
    logic       pix_valid_r;

    // Dynamic bypass overrides format, addressing and fill
    assign dyn_w    = (hipath_w == `VPU_PATH_DYN);
    assign is565_w  = f565_w && !dyn_w;
    assign sparse_w = !contig_w || dyn_w;
    assign fill_w   = lin_w && !dyn_w;

    // Fields high to low; 5:5:5 leaves the top bit for control
    always_comb begin
        b5_w = raw_w[`VPU_P_B];
        if (is565_w) begin
            r5_w = raw_w[`VPU_P565_R];
            g6_w = raw_w[`VPU_P565_G];
        end else begin
            r5_w = raw_w[`VPU_P555_R];
            g6_w = {1'b0, raw_w[`VPU_P555_G]};
        end
    end

    // Path decode; unused code 10 falls back to lookup
    always_comb begin
        unique case (hipath_w)
            `VPU_PATH_DIR: direct_w = 1'b1;
            `VPU_PATH_DYN: direct_w = raw_w[`VPU_P_CTL] ^ pol_w;
            default:       direct_w = 1'b0;
        endcase
    end

    always_comb begin
        red_nxt   = 8'h00;
        grn_nxt   = 8'h00;
        blu_nxt   = 8'h00;
        byp_nxt   = 1'b0;
        valid_nxt = busy_w;
        unique case (fmt_w)
            vpu_pkg::VPU_FMT_4: begin
                // Bank forms the partition; upper mask bits unused
                red_nxt = {bank_w, raw_w[3:0] & pmask_w[3:0]};
                grn_nxt = red_nxt;
                blu_nxt = red_nxt;
            end
            vpu_pkg::VPU_FMT_16: begin
                byp_nxt = direct_w;
                if (direct_w) begin
                    red_nxt = fill_w ? {r5_w, r5_w[4:2]}
                                     : {r5_w, 3'b000};
                    blu_nxt = fill_w ? {b5_w, b5_w[4:2]}
                                     : {b5_w, 3'b000};
                    if (is565_w) begin
                        grn_nxt = fill_w ? {g6_w, g6_w[5:4]}
                                         : {g6_w, 2'b00};
                    end else begin
                        grn_nxt = fill_w ? {g6_w[4:0], g6_w[4:2]}
                                         : {g6_w[4:0], 3'b000};
                    end
                    // Mask still applies to bypassed dynamic pixels
                    if (dyn_w) begin
                        red_nxt = red_nxt & pmask_w;
                        grn_nxt = grn_nxt & pmask_w;
                        blu_nxt = blu_nxt & pmask_w;
                    end
                end else if (sparse_w) begin
                    // Zero low bits make low mask bits irrelevant
                    red_nxt = {r5_w, 3'b000} & pmask_w;
                    blu_nxt = {b5_w, 3'b000} & pmask_w;
                    grn_nxt = is565_w ? ({g6_w, 2'b00} & pmask_w)
                                      : ({g6_w[4:0], 3'b000}
                                         & pmask_w);
                end else if (is565_w) begin
                    // Four banks; red and blue in lower 32 of each
                    red_nxt = {bank_w[1:0], 1'b0,
                               r5_w & pmask_w[4:0]};
                    blu_nxt = {bank_w[1:0], 1'b0,
                               b5_w & pmask_w[4:0]};
                    grn_nxt = {bank_w[1:0], g6_w & pmask_w[5:0]};
                end else begin
                    // Eight banks of 32 entries
                    red_nxt = {bank_w[2:0], r5_w & pmask_w[4:0]};
                    blu_nxt = {bank_w[2:0], b5_w & pmask_w[4:0]};
                    grn_nxt = {bank_w[2:0],
                               g6_w[4:0] & pmask_w[4:0]};
                end
            end
            default: begin
                // Same byte to all three, masked only for lookup
                byp_nxt = b8_dir_w;
                red_nxt = b8_dir_w ? raw_w[7:0]
                                   : (raw_w[7:0] & pmask_w);
                grn_nxt = red_nxt;
                blu_nxt = red_nxt;
            end
        endcase
    end

    // Output stage; one pixel per clock while a word is held
    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pix_red_r   <= 8'h00;
            pix_grn_r   <= 8'h00;
            pix_blu_r   <= 8'h00;
            pix_byp_r   <= 1'b0;
            pix_valid_r <= 1'b0;
        end else begin
            pix_red_r   <= red_nxt;
            pix_grn_r   <= grn_nxt;
            pix_blu_r   <= blu_nxt;
            pix_byp_r   <= byp_nxt;
            pix_valid_r <= valid_nxt;
        end
    end

    assign pix_red_o    = pix_red_r;
    assign pix_grn_o    = pix_grn_r;
    assign pix_blu_o    = pix_blu_r;
    assign pix_bypass_o = pix_byp_r;
    assign pix_valid_o  = pix_valid_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks; configuration is assumed steady across a word
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_r);

    first_byte_a: assert property (
        take_w && fmt_w == vpu_pkg::VPU_FMT_8 && b8_dir_w && !byte_swap_w
        |-> ##2 pix_red_o == $past(pixel_port_bus_i[7:0], 2))
        else $error("first 8-bit pixel not from bit 0");

    nib_order_a: assert property (
        take_w && fmt_w == vpu_pkg::VPU_FMT_4 && !byte_swap_w
        |-> ##2 pix_red_o[3:0] == ((nib_swap_w
                ? $past(pixel_port_bus_i[3:0], 2)
                : $past(pixel_port_bus_i[7:4], 2)) & pmask_w[3:0]))
        else $error("4-bit nibble order wrong");

    byte_swap_a: assert property (
        take_w && fmt_w == vpu_pkg::VPU_FMT_8 && b8_dir_w && byte_swap_w
        |-> ##2 pix_red_o == $past(pixel_port_bus_i[15:8], 2))
        else $error("byte pair not exchanged");

    four_count_a: assert property (
        take_w && fmt_w == vpu_pkg::VPU_FMT_4 && !w64_w
        |=> !word_ready_o [*7] ##1 word_ready_o)
        else $error("4 bpp pixel count wrong");

    eight_count_a: assert property (
        take_w && fmt_w == vpu_pkg::VPU_FMT_8 && !w64_w
        |=> !word_ready_o [*3] ##1 word_ready_o)
        else $error("8 bpp pixel count wrong");

    hi_count_a: assert property (
        take_w && fmt_w == vpu_pkg::VPU_FMT_16 && w64_w
        |=> !word_ready_o [*3] ##1 word_ready_o)
        else $error("16 bpp pixel count wrong");

    four_index_a: assert property (
        pix_valid_o && $past(fmt_w) == vpu_pkg::VPU_FMT_4
        |-> !pix_bypass_o && pix_red_o[7:4] == $past(bank_w)
            && pix_grn_o == pix_red_o)
        else $error("4-bit index not banked lookup");

    byte_mono_a: assert property (
        pix_valid_o && $past(fmt_w) == vpu_pkg::VPU_FMT_8
        |-> pix_bypass_o == $past(b8_dir_w) && pix_red_o == pix_blu_o)
        else $error("8-bit pixel channels differ");

    dyn_sel_a: assert property (
        take_w && fmt_w == vpu_pkg::VPU_FMT_16 && dyn_w && !byte_swap_w
        |-> ##2 pix_bypass_o == ($past(pixel_port_bus_i[15], 2) ^ pol_w))
        else $error("dynamic bypass polarity wrong");

    zero_fill_a: assert property (
        pix_valid_o && pix_bypass_o && $past(fmt_w) == vpu_pkg::VPU_FMT_16
        && !$past(fill_w)
        |-> pix_red_o[2:0] == 3'b000 && pix_blu_o[2:0] == 3'b000)
        else $error("zero fill low bits not zero");

    sparse_low_a: assert property (
        pix_valid_o && !pix_bypass_o && $past(fmt_w) == vpu_pkg::VPU_FMT_16
        && $past(sparse_w)
        |-> pix_red_o[2:0] == 3'b000)
        else $error("sparse index low bits set");

    contig_bank_a: assert property (
        pix_valid_o && !pix_bypass_o && $past(fmt_w) == vpu_pkg::VPU_FMT_16
        && !$past(sparse_w) && !$past(is565_w)
        |-> pix_red_o[7:5] == $past(bank_w[2:0]))
        else $error("contiguous bank bits wrong");

endmodule

// >>> vpu_vram_src.sv
// Video memory model that offers words on the pixel port
`timescale 1ns/10ps

module vpu_vram_src (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        go_i,
    input  wire logic        ready_i,
    input  wire logic [63:0] word_i,
    output logic             load_o,
    output logic      [63:0] bus_o
);
    // Hold each word until taken; an idle bus toggles so stale data never
    // passes for a fresh word
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_o <= 1'b0;
            bus_o  <= 64'h0000_0000_0000_0000;
        end else if (!load_o || ready_i) begin
            load_o <= go_i;
            bus_o  <= go_i ? word_i : ~bus_o;
        end
    end
endmodule

// >>> tb_top.sv
// Self-checking bench for the pixel unpacker
`timescale 1ns/10ps

module tb_top;
    typedef struct packed {
        logic [11:0] ctrl;
        logic [11:0] mask;
        logic [63:0] w;
        logic [4:0]  n;
        logic [24:0] p0;
        logic [24:0] p1;
    } vpu_row_t;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        go = 1'b0;
    logic [63:0] word = 64'h0000_0000_0000_0000;
    logic        load;
    logic [63:0] bus;
    logic        ready;
    logic        pv;
    logic        pb;
    logic [7:0]  pr;
    logic [7:0]  pg;
    logic [7:0]  pbl;
    logic [24:0] got[$];
    logic [31:0] q;
    logic        e;
    int          bad_count = 0;
    int          samples_checked = 0;
    // Pixel expectations are {bypass, red, green, blue}
    vpu_row_t    rows[15] = '{
        '{12'h001, 12'h00F, 64'h4433_2211, 5'd4, 25'h001_0101, 25'h002_0202},
        '{12'h025, 12'h0FF, 64'h8877_6655_4433_2211, 5'd8, 25'h111_1111,
          25'h122_2222},
        '{12'h000, 12'h5F6, 64'h00A7, 5'd8, 25'h052_5252, 25'h056_5656},
        '{12'h00C, 12'h0FF, 64'h00A7, 5'd16, 25'h007_0707, 25'h00A_0A0A},
        '{12'h031, 12'h0FF, 64'h2211, 5'd4, 25'h122_2222, 25'h111_1111},
        '{12'h009, 12'h0FF, 64'h2211, 5'd4, 25'h011_1111, 25'h022_2222},
        '{12'h002, 12'h0F8, 64'h5559_D559, 5'd2, 25'h0A8_50C8, 25'h0A8_50C8},
        '{12'h8C2, 12'h0FF, 64'hD559, 5'd2, 25'h1D0_A8C8, 25'h100_0000},
        '{12'hAC2, 12'h0FF, 64'hD559, 5'd2, 25'h1D6_AACE, 25'h100_0000},
        '{12'h402, 12'h51F, 64'hD559, 5'd2, 25'h0B5_AAB9, 25'h0A0_A0A0},
        '{12'hE42, 12'h0F0, 64'h5559_D559, 5'd2, 25'h1A0_50C0, 25'h0A0_50C0},
        '{12'hF42, 12'h0F0, 64'h5559_D559, 5'd2, 25'h0A0_50C0, 25'h1A0_50C0},
        '{12'h0C6, 12'h0FF, 64'hD559, 5'd4, 25'h1A8_50C8, 25'h100_0000},
        '{12'h802, 12'h0FF, 64'hD559, 5'd2, 25'h0D0_A8C8, 25'h000_0000},
        '{12'hC02, 12'h6FF, 64'hD559, 5'd2, 25'h09A_AA99, 25'h080_8080}
    };

    always #2.5 ref_clk = ~ref_clk;

    vpu_unpacker i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .word_load_clock_i(load),
        .pixel_port_bus_i(bus), .word_ready_o(ready), .pix_valid_o(pv),
        .pix_bypass_o(pb), .pix_red_o(pr), .pix_grn_o(pg), .pix_blu_o(pbl));

    vpu_vram_src i_src (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .go_i(go),
        .ready_i(ready), .word_i(word), .load_o(load), .bus_o(bus));

    // Collect every pixel the design presents
    always @(posedge ref_clk) begin
        if (pv === 1'b1) begin
            got.push_back({pb, pr, pg, pbl});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] %0t mismatch got %h exp %h", $time, g, x);
        end
    endtask

    // One APB transfer; waits for pready rather than assuming zero waits
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so a following call never re-drives psel at once
        @(posedge ref_clk);
    endtask

    // Words enter back to back; the model is told one edge ahead of a take
    task automatic send(input logic [63:0] w0, input logic [63:0] w1,
                        input int n);
        for (int i = 0; i < n; i++) begin
            word <= (i == 0) ? w0 : w1;
            go <= 1'b1;
            do @(negedge ref_clk); while (load && !ready);
            @(posedge ref_clk);
        end
        go <= 1'b0;
    endtask

    task automatic run_row(input vpu_row_t r);
        apb(1'b1, 8'h00, {20'h0_0000, r.ctrl});
        apb(1'b1, 8'h04, {20'h0_0000, r.mask});
        got.delete();
        send(r.w, r.w, 1);
        for (int k = 0; k < 60 && got.size() < r.n; k++) @(negedge ref_clk);
        repeat (6) @(negedge ref_clk);
        cmp(got.size(), r.n);
        cmp(got[0], r.p0);
        cmp(got[1], r.p1);
        @(posedge ref_clk);
    endtask

    task automatic give_verdict;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog sized well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        apb(1'b0, 8'h00, 32'h0000_0000);
        cmp(q, 32'h0000_0000);
        apb(1'b0, 8'h04, 32'h0000_0000);
        cmp(q, 32'h0000_00FF);
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        cmp({31'h0000_0000, e}, 32'h0000_0001);
        // Sparse rows keep zero fill, as software must, except row 12'hAC2, a direct row with fill on
        foreach (rows[i]) run_row(rows[i]);
        // Two words back to back must give an unbroken pixel run
        apb(1'b1, 8'h00, 32'h0000_0001);
        apb(1'b1, 8'h04, 32'h0000_00FF);
        got.delete();
        send(64'h4433_2211, 64'h8877_6655, 2);
        for (int k = 0; k < 60 && got.size() == 0; k++) @(negedge ref_clk);
        repeat (7) @(negedge ref_clk);
        // Counted off the edge, so a one-cycle gap shows as a short run
        cmp(got.size(), 32'd8);
        cmp(got[4], 25'h055_5555);
        @(posedge ref_clk);
        apb(1'b0, 8'h08, 32'h0000_0000);
        cmp({16'h0000, q[15:0]}, 32'd17);
        // Reset while idle empties the pixel path and clears control
        rst_n <= 1'b0;
        repeat (2) @(negedge ref_clk);
        cmp({30'h0000_0000, pv, ready}, 32'h0000_0001);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        apb(1'b0, 8'h00, 32'h0000_0000);
        cmp(q, 32'h0000_0000);
        give_verdict();
    end
endmodule
